/* rtl/dec_pkg.sv */
// Constants, field layouts and carriers for the data store controller.
// Assumes a single system clock domain and a synchronous active-high reset.
// ----------------------------------------------------------------------------
// Summary of operation
// [R01] Store holds 128 bytes of eight bits, addresses 0x00 to 0x7F.
// [R02] Store is not memory mapped; every access moves exactly one byte.
// [R03] Control register sits at offset 0x40 of sector 1, reached indirectly.
// [R04] Address and data registers sit in sector 0, accessed directly.
// [R05] Address register holds seven bits, cleared at reset; bit 7 reads zero.
// [R06] Data register is eight bits read/write, cleared at reset.
// [R07] Control bits 7..4 read zero; bits 3..0 are enables and starts.
// [R08] Writes to the store are blocked while write enable is zero.
// [R09] Setting write start begins a write of data to the addressed byte.
// [R10] Write start clears itself when the write cycle finishes.
// [R11] Write start without write enable already set starts nothing.
// [R12] Reads from the store are blocked while read enable is zero.
// [R13] Setting read start begins a read of the addressed byte.
// [R14] Read start clears itself when the read cycle finishes.
// [R15] Read start without read enable already set starts nothing.
// [R16] Fetched byte lands in data register and stays until next operation.
// [R17] Software sets write enable, then write start, in consecutive cycles.
// [R18] Software never sets all four control bits in one instruction.
// [R19] End of every write cycle raises a write-done request flag.
// [R20] Write cycle lasts a configurable tick count; write start stays high.
// ----------------------------------------------------------------------------
package dec_pkg;
  localparam int DEC_DEPTH = 128;
  localparam int DEC_AW = 7;
  localparam int DEC_DW = 8;
  localparam logic [7:0] DEC_CTRL_OFFSET = 8'h40;
  localparam logic [7:0] DEC_CTRL_SECTOR = 8'h01;
  localparam logic [7:0] DEC_DIRECT_SECTOR = 8'h00;
  localparam int DEC_BIT_WRITE_EN = 3;
  localparam int DEC_BIT_WRITE_GO = 2;
  localparam int DEC_BIT_READ_EN = 1;
  localparam int DEC_BIT_READ_GO = 0;
  localparam logic [7:0] DEC_RESET_ADDRESS = 8'h00;
  localparam logic [7:0] DEC_RESET_DATA = 8'h00;
  localparam logic [3:0] DEC_RESET_CONTROL = 4'h0;
  localparam int DEC_CLOCK_MHZ = 125;
  localparam int DEC_TICK_NS = 1000;
  localparam int DEC_TICK_CYCLES = (DEC_TICK_NS * DEC_CLOCK_MHZ + 999) / 1000;
  localparam int DEC_WRITE_TICKS = 16;
  localparam int DEC_READ_CYCLES = 2;

  typedef struct packed {
    logic write_en;
    logic write_go;
    logic read_en;
    logic read_go;
  } dec_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dec_reg_req_t;
endpackage : dec_pkg

/* rtl/dec_tick.sv */
// Divider giving one-cycle tick pulses for timing the write cycle.
// Assumes the system clock; run gates counting so each cycle starts aligned.
`timescale 1ns/10ps
module dec_tick
  import dec_pkg::*;
#(
  parameter int DIVIDE = DEC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic run,
  output logic tick
);
  localparam int CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);
  logic [CW-1:0] count;
  wire at_last = (count == LAST);

  always_ff @(posedge clock) begin
    if (rst || !run) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= at_last ? '0 : count + 1'b1;
      tick <= at_last;
    end
  end
endmodule : dec_tick

/* rtl/dec_store.sv */
// Byte store array of flip-flops standing in for the non-volatile cells.
// Assumes one access per cycle; read data is registered.
`timescale 1ns/10ps
module dec_store
  import dec_pkg::*;
#(
  parameter int DEPTH = DEC_DEPTH,
  parameter int AW = DEC_AW,
  parameter int DW = DEC_DW
) (
  // Clock
  input wire logic clock,
  // Access port
  input wire logic write,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] cells [DEPTH];

  // Contents survive reset, as non-volatile cells would
  always_ff @(posedge clock) begin
    if (write) begin
      cells[addr] <= wdata; // see [R01]
    end
    rdata <= cells[addr];
  end
endmodule : dec_store

/* rtl/dec_ctrl.sv */
// Top of the data store controller: register file and access sequencing.
// Assumes the core presents one register access per cycle with a sector
// number already resolved from its pointer high byte.
`timescale 1ns/10ps
module dec_ctrl
  import dec_pkg::*;
#(
  parameter int WRITE_TICKS = DEC_WRITE_TICKS,
  parameter int TICK_CYCLES = DEC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Direct sector 0 access, address register
  input wire logic address_we,
  input wire logic [7:0] address_wdata,
  output logic [7:0] nvm_address,
  // Direct sector 0 access, data register
  input wire logic data_we,
  input wire logic [7:0] data_wdata,
  output logic [7:0] nvm_data,
  // Indirect access port
  input wire logic [7:0] indirect_sector,
  input wire logic [7:0] indirect_offset,
  input wire logic indirect_we,
  input wire logic [7:0] indirect_wdata,
  output logic [7:0] indirect_rdata,
  // Event to the interrupt logic
  output logic write_done_irq_flag
);
  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {DEC_IDLE, DEC_WRITING, DEC_READING} dec_state_t;
  localparam int TW = $clog2(WRITE_TICKS + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(WRITE_TICKS - 1);
  localparam logic [1:0] READ_LAST = 2'(DEC_READ_CYCLES - 1);

  dec_state_t state;
  dec_state_t next_state;
  dec_ctrl_t ctrl;
  dec_ctrl_t next_ctrl;
  logic [TW-1:0] ticks;
  logic [1:0] read_count;
  logic [7:0] next_data;
  logic tick;
  logic [DEC_DW-1:0] store_rdata;

  wire ctrl_hit = (indirect_sector == DEC_CTRL_SECTOR) &&
                  (indirect_offset == DEC_CTRL_OFFSET); // see [R03]
  wire ctrl_we = indirect_we && ctrl_hit;
  wire busy = (state != DEC_IDLE);
  wire [3:0] wr_bits = indirect_wdata[3:0];
  // Starts honour the enable as held before this write
  wire start_write = ctrl_we && !busy && wr_bits[DEC_BIT_WRITE_GO] &&
                     ctrl.write_en; // see [R11]
  wire start_read = ctrl_we && !busy && !start_write &&
                    wr_bits[DEC_BIT_READ_GO] && ctrl.read_en; // see [R15]
  wire write_end = (state == DEC_WRITING) && tick && (ticks == TICK_LAST);
  wire read_end = (state == DEC_READING) && (read_count == READ_LAST);
  // Write only lands while enable still high at cycle end
  wire store_write = write_end && ctrl.write_en; // see [R08]
  wire [DEC_AW-1:0] store_addr = nvm_address[DEC_AW-1:0];
  // Indirect read of control; bits 7..4 zero, other offsets read zero
  wire [7:0] ctrl_read = {4'h0, ctrl}; // see [R07]

  // --------------------------------------------------------------------------
  // Next control and data
  // --------------------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_we) begin
      next_ctrl.write_en = wr_bits[DEC_BIT_WRITE_EN];
      next_ctrl.read_en = wr_bits[DEC_BIT_READ_EN];
      // Busy start bits cannot be cleared early; would corrupt timing
      if (!busy) begin
        next_ctrl.write_go = start_write; // see [R09]
        next_ctrl.read_go = start_read; // see [R13]
      end
    end
    if (write_end) begin
      next_ctrl.write_go = 1'b0; // see [R10]
    end
    if (read_end) begin
      next_ctrl.read_go = 1'b0; // see [R14]
    end
  end

  always_comb begin
    next_data = nvm_data;
    if (data_we && !busy) begin
      next_data = data_wdata; // see [R06]
    end
    // Read blocked if read enable dropped mid cycle
    if (read_end && ctrl.read_en) begin
      next_data = store_rdata; // see [R12] see [R16]
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      DEC_IDLE: begin
        if (start_write) begin
          next_state = DEC_WRITING;
        end else if (start_read) begin
          next_state = DEC_READING;
        end
      end
      DEC_WRITING: begin
        if (write_end) begin
          next_state = DEC_IDLE;
        end
      end
      DEC_READING: begin
        if (read_end) begin
          next_state = DEC_IDLE;
        end
      end
      default: next_state = DEC_IDLE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= DEC_IDLE;
      ctrl <= DEC_RESET_CONTROL;
      nvm_data <= DEC_RESET_DATA;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      nvm_data <= next_data;
    end
  end

  // Address frozen while busy so the cycle targets one byte only
  always_ff @(posedge clock) begin
    if (rst) begin
      nvm_address <= DEC_RESET_ADDRESS;
    end else if (address_we && !busy) begin
      nvm_address <= {1'b0, address_wdata[6:0]}; // see [R04] see [R05]
    end
  end

  always_ff @(posedge clock) begin
    if (rst || state != DEC_WRITING) begin
      ticks <= '0;
    end else if (tick) begin
      ticks <= ticks + 1'b1; // see [R20]
    end
  end

  always_ff @(posedge clock) begin
    if (rst || state != DEC_READING) begin
      read_count <= 2'h0;
    end else begin
      read_count <= read_count + 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      write_done_irq_flag <= 1'b0;
      indirect_rdata <= 8'h00;
    end else begin
      write_done_irq_flag <= write_end; // see [R19]
      indirect_rdata <= ctrl_hit ? ctrl_read : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  dec_tick #(.DIVIDE(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst(rst),
    .run(state == DEC_WRITING),
    .tick(tick)
  );

  // One byte per access, never mapped into core memory
  dec_store u_store (
    .clock(clock),
    .write(store_write), // see [R02]
    .addr(store_addr),
    .wdata(nvm_data),
    .rdata(store_rdata)
  );
endmodule : dec_ctrl

/* dv/dec_monitor.sv */
// Checker for the data store controller, bound to dec_ctrl.
// Assumes it sees only the ports of dec_ctrl, one clock domain.
`timescale 1ns/10ps
module dec_monitor #(
  parameter int WRITE_TICKS = 2,
  parameter int TICK_CYCLES = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register ports
  input wire logic address_we,
  input wire logic data_we,
  input wire logic [7:0] nvm_address,
  input wire logic [7:0] nvm_data,
  input wire logic [7:0] indirect_sector,
  input wire logic [7:0] indirect_offset,
  input wire logic indirect_we,
  input wire logic [7:0] indirect_wdata,
  input wire logic [7:0] indirect_rdata,
  input wire logic write_done_irq_flag
);
  localparam int WAIT_MAX = WRITE_TICKS * TICK_CYCLES + 8;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic hit = indirect_we && indirect_sector == 8'h01 && indirect_offset == 8'h40;
  logic wen_q;
  logic ren_q;
  logic [3:0] arm;
  // Enables as last written, so a start can be judged against them
  always_ff @(posedge clock) begin
    if (rst) begin
      wen_q <= 1'b0;
      ren_q <= 1'b0;
    end else if (hit) begin
      wen_q <= indirect_wdata[3];
      ren_q <= indirect_wdata[1];
    end
  end
  // Window in which a read may load the data register
  always_ff @(posedge clock) begin
    if (rst) begin
      arm <= 4'h0;
    end else if (hit && indirect_wdata[0]) begin
      arm <= 4'hF;
    end else if (arm != 4'h0) begin
      arm <= arm - 4'h1;
    end
  end
  sequence s_write_go;
    hit && indirect_wdata[3:2] == 2'b11 && wen_q;
  endsequence
  sequence s_write_bare;
    hit && indirect_wdata[3:2] == 2'b01 && !wen_q;
  endsequence
  sequence s_read_bare;
    hit && indirect_wdata[1:0] == 2'b01 && !ren_q && !data_we;
  endsequence
  a_addr_top_zero: assert property (nvm_address[7] == 1'b0)
    else $error("address bit 7 set");
  a_ctrl_top_zero: assert property (indirect_rdata[7:4] == 4'h0)
    else $error("control upper bits set");
  a_reset_clears: assert property (disable iff (1'b0) rst |=> nvm_address == 8'h00 &&
    nvm_data == 8'h00 && indirect_rdata == 8'h00) else $error("reset values wrong");
  a_irq_one_pulse: assert property (write_done_irq_flag |=> !write_done_irq_flag)
    else $error("done flag longer than a cycle");
  a_other_place: assert property (!(indirect_sector == 8'h01 &&
    indirect_offset == 8'h40) |=> indirect_rdata == 8'h00) else $error("stray readback");
  a_addr_held: assert property (!address_we |=> $stable(nvm_address))
    else $error("address changed unasked");
  a_data_source: assert property (!$past(rst) && $changed(nvm_data) |->
    $past(data_we) || arm != 4'h0) else $error("data changed without cause");
  a_write_done: assert property (s_write_go |-> ##[1:WAIT_MAX] write_done_irq_flag)
    else $error("write cycle never ended");
  a_write_blocked: assert property (s_write_bare |=> !write_done_irq_flag [*8])
    else $error("write ran without enable");
  a_read_blocked: assert property (s_read_bare |=> $stable(nvm_data) [*4])
    else $error("read ran without enable");
endmodule : dec_monitor

/* dv/dec_ctrl_bench.sv */
// Self-checking bench for the data store controller at its register ports.
// Assumes short write timing parameters and a 125 MHz clock.
`timescale 1ns/10ps
module dec_ctrl_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic address_we = 1'b0, data_we = 1'b0, indirect_we = 1'b0, write_done_irq_flag;
  logic [7:0] address_wdata = 8'h00, data_wdata = 8'h00, indirect_wdata = 8'h00;
  logic [7:0] indirect_sector = 8'h00, indirect_offset = 8'h00;
  logic [7:0] nvm_address, nvm_data, indirect_rdata, v;
  logic [7:0] addrs [3] = '{8'h00, 8'h7F, 8'h40};
  logic [7:0] datas [3] = '{8'h3C, 8'hC3, 8'h5A};
  int n_fail = 0, n_compared = 0, cycles = 0;
  int n_done = 0;
  always #4 clock = ~clock;
  // Done pulses counted away from the edge that launches them
  always @(negedge clock) begin
    if (write_done_irq_flag === 1'b1) begin
      n_done++;
    end
  end
  dec_ctrl #(.WRITE_TICKS(4), .TICK_CYCLES(2)) dut (.clock(clock), .rst(rst),
    .address_we(address_we), .address_wdata(address_wdata), .nvm_address(nvm_address),
    .data_we(data_we), .data_wdata(data_wdata), .nvm_data(nvm_data),
    .indirect_sector(indirect_sector), .indirect_offset(indirect_offset),
    .indirect_we(indirect_we), .indirect_wdata(indirect_wdata),
    .indirect_rdata(indirect_rdata), .write_done_irq_flag(write_done_irq_flag));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Which: 0 address, 1 data, 2 control through the pointer
  task automatic wr_reg(input int which, input logic [7:0] val);
    @(negedge clock);
    {address_wdata, data_wdata, indirect_wdata} = {3{val}};
    {indirect_sector, indirect_offset} = 16'h0140;
    {address_we, data_we, indirect_we} = 3'b100 >> which;
    @(negedge clock);
    {address_we, data_we, indirect_we} = 3'b000;
  endtask : wr_reg
  // Two control writes in consecutive cycles, strobe held between them
  task automatic wr_pair(input logic [7:0] val_a, input logic [7:0] val_b);
    @(negedge clock);
    indirect_wdata = val_a;
    {indirect_sector, indirect_offset} = 16'h0140;
    indirect_we = 1'b1;
    @(negedge clock);
    indirect_wdata = val_b;
    @(negedge clock);
    indirect_we = 1'b0;
  endtask : wr_pair
  task automatic rd_ind(input logic [7:0] sec, input logic [7:0] off);
    @(negedge clock);
    {indirect_sector, indirect_offset} = {sec, off};
    @(negedge clock);
    v = indirect_rdata;
  endtask : rd_ind
  task automatic poll(input logic [7:0] mask);
    for (int i = 0; i < 60 && (i == 0 || (v & mask) != 8'h00); i++) begin
      rd_ind(8'h01, 8'h40);
    end
  endtask : poll
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Ceiling well above the some 140 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    rd_ind(8'h01, 8'h40);
    check(v, 8'h00);
    check(nvm_address, 8'h00);
    check(nvm_data, 8'h00);
    wr_reg(0, 8'hFF);
    check(nvm_address, 8'h7F);
    wr_reg(2, 8'h04);
    rd_ind(8'h01, 8'h40);
    check(v, 8'h00);
    check(n_done[7:0], 8'h00);
    $display("test reset and refusal done");
    for (int k = 0; k < 3; k++) begin
      wr_reg(0, addrs[k]);
      wr_reg(1, datas[k]);
      wr_pair(8'h08, 8'h0C);
      rd_ind(8'h01, 8'h40);
      check(v, 8'h0C);
      wr_reg(0, 8'h11);
      check(nvm_address, addrs[k]);
      poll(8'h04);
      check(v, 8'h08);
      check(n_done[7:0], 8'(k + 1));
      wr_reg(1, 8'h00);
      wr_pair(8'h02, 8'h03);
      poll(8'h01);
      check(v, 8'h02);
      check(nvm_data, datas[k]);
      wr_reg(2, 8'h00);
      check(nvm_data, datas[k]);
    end
    $display("test write and read back done");
    // Enable dropped mid cycle: cycle completes, byte keeps its old value
    wr_reg(0, 8'h7F);
    wr_reg(1, 8'hA5);
    wr_pair(8'h08, 8'h0C);
    wr_reg(2, 8'h04);
    poll(8'h04);
    check(v, 8'h00);
    check(n_done[7:0], 8'h04);
    wr_pair(8'h02, 8'h03);
    poll(8'h01);
    check(nvm_data, 8'hC3);
    wr_reg(2, 8'h00);
    $display("test write abort done");
    wr_reg(1, 8'h5A);
    wr_reg(2, 8'h01);
    rd_ind(8'h01, 8'h40);
    check(v, 8'h00);
    check(nvm_data, 8'h5A);
    wr_reg(2, 8'h08);
    rd_ind(8'h00, 8'h40);
    check(v, 8'h00);
    rd_ind(8'h01, 8'h41);
    check(v, 8'h00);
    rd_ind(8'h01, 8'h40);
    check(v, 8'h08);
    $display("test blocked read and placement done");
    @(negedge clock);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    check(nvm_address, 8'h00);
    check(nvm_data, 8'h00);
    rd_ind(8'h01, 8'h40);
    check(v, 8'h00);
    $display("test second reset done");
    finish_test();
  end
endmodule : dec_ctrl_bench
bind dec_ctrl dec_monitor #(.WRITE_TICKS(WRITE_TICKS), .TICK_CYCLES(TICK_CYCLES)) u_mon (
  .clock(clock), .rst(rst), .address_we(address_we), .data_we(data_we),
  .nvm_address(nvm_address), .nvm_data(nvm_data), .indirect_sector(indirect_sector),
  .indirect_offset(indirect_offset), .indirect_we(indirect_we),
  .indirect_wdata(indirect_wdata), .indirect_rdata(indirect_rdata),
  .write_done_irq_flag(write_done_irq_flag));
